// ==== bench/spi_far_end.sv ====
`timescale 1ns/1ps
`default_nettype none

// Far-end SPI slave: takes MOSI and answers with a preset word on MISO
module spi_far_end (
  input wire logic sck,
  input wire logic mosi,
  input wire logic arm,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb_first,
  input wire logic [4:0] nbits,
  input wire logic [15:0] tx_word,
  output logic miso,
  output logic [15:0] rx_word,
  output logic [4:0] n_smp
);
  logic [4:0] n_out;
  logic lead;

  function automatic logic pick(input logic [4:0] i);
    return lsb_first ? tx_word[i[3:0]] : tx_word[4'(nbits - 5'd1 - i)];
  endfunction

  initial miso = 1'b0;

  // Rearm per word; with phase 0 the first bit goes out at once, before any edge
  always @(posedge arm) begin
    n_smp = 5'd0;
    rx_word = 16'h0000;
    n_out = cpha ? 5'd0 : 5'd1;
    miso = cpha ? ~miso : pick(5'd0);
  end

  // Sample on one edge, launch on the other, as the device is set up
  // Past the word the line shows the inverse, so stale bits never pass
  always @(sck) begin
    lead = (sck != cpol);
    if (lead != cpha) begin
      if (n_smp < nbits) begin
        if (lsb_first) rx_word[n_smp[3:0]] = mosi;
        else rx_word = {rx_word[14:0], mosi};
        n_smp = n_smp + 5'd1;
      end
      if (cpha && n_smp >= nbits) miso = ~miso;
    end else begin
      miso = (n_out < nbits) ? pick(n_out) : ~miso;
      n_out = n_out + 5'd1;
    end
  end
endmodule

`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import spi_core_pkg::*;
;
  typedef struct packed {
    logic pha, pol, lsb;
    logic [3:0] wl;
    logic [15:0] div, tx, far, efar;
  } row_s;
  // Phase, polarity, order, length and divider mixes
  row_s rows [6] = '{
    '{1'b0, 1'b0, 1'b0, 4'h7, 16'h0001, 16'h00A5, 16'h003C, 16'h00A5},
    '{1'b1, 1'b0, 1'b1, 4'h7, 16'h0002, 16'h1234, 16'h00C1, 16'h0034},
    '{1'b0, 1'b1, 1'b1, 4'hF, 16'h0003, 16'hBEEF, 16'h8001, 16'hBEEF},
    '{1'b1, 1'b1, 1'b0, 4'h0, 16'h0009, 16'h0001, 16'h0001, 16'h0001},
    '{1'b0, 1'b1, 1'b0, 4'h3, 16'h0009, 16'h00FA, 16'h0006, 16'h000A},
    '{1'b1, 1'b1, 1'b1, 4'hF, 16'h0001, 16'h0F0E, 16'h7001, 16'h0F0E}};
  row_s r;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err, arm, cts;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, sel_out, sel_oe;
  logic sck_drv, mosi_drv, sel_drv, far_miso, sck_w, mosi_w, miso_w, sel_w, sck_q;
  logic dma_tx_req, dma_rx_req, f_pol, f_pha, f_lsb;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] f_bits, f_cnt;
  logic [15:0] f_tx, f_rx;
  logic [7:0] got;
  int n_errors = 0;
  int num_checks = 0;
  int half = 0;
  int run = 0;

  always #2.5 pclk = ~pclk;

  // Shared pins resolve to whichever party enables its driver
  assign sck_w = sck_oe ? sck_out : sck_drv;
  assign mosi_w = mosi_oe ? mosi_out : mosi_drv;
  assign miso_w = miso_oe ? miso_out : far_miso;
  assign sel_w = sel_oe ? sel_out : sel_drv;

  spi_format_clock_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe), .sel_in(sel_w), .sel_out(sel_out),
    .sel_oe(sel_oe), .clear_to_send(cts), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
  spi_far_end i_far (.sck(sck_w), .mosi(mosi_w), .arm(arm), .cpol(f_pol), .cpha(f_pha),
    .lsb_first(f_lsb), .nbits(f_bits), .tx_word(f_tx), .miso(far_miso), .rx_word(f_rx),
    .n_smp(f_cnt));

  // SCK half period in pclk cycles, sampled mid-cycle away from the launch edge
  always @(negedge pclk) begin
    if (sck_out !== sck_q) begin
      half = run;
      run = 0;
    end
    run++;
    sck_q = sck_out;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait on a slave that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // Poll until idle with the given receive level; the poll count bounds the wait
  task automatic wait_lvl(input logic [3:0] lvl);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0, rd);
      n++;
    end while ((rd[6:3] !== lvl || rd[11] !== 1'b0) && n < 300);
    chk("rx level", {28'h0, rd[6:3]}, {28'h0, lvl});
  endtask

  // External master word, mode 0, SCK at pclk over ten
  task automatic slave_word(input logic [7:0] m);
    for (int b = 7; b >= 0; b--) begin
      mosi_drv <= m[b];
      repeat (5) @(posedge pclk);
      got[b] = miso_w;
      sck_drv <= 1'b1;
      repeat (5) @(posedge pclk);
      sck_drv <= 1'b0;
    end
    repeat (5) @(posedge pclk);
  endtask

  function automatic logic [31:0] cfg(input logic [1:0] md, input logic [3:0] wl,
      input logic [6:0] low);
    return {19'h0_0000, md, wl, low};
  endfunction

  initial begin
    #200_000;
    n_errors++;
    $display("MISMATCH watchdog exp done seen hang");
    wrap_up();
  end

  initial begin
    {psel, penable, pwrite, arm, sck_drv, mosi_drv, f_pol, f_pha, f_lsb} = '0;
    {paddr, pwdata, f_tx} = '0;
    {sel_drv, cts, presetn} = 3'b110;
    f_bits = 5'd1;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("oe in reset", {28'h0, sck_oe, mosi_oe, miso_oe, sel_oe}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CONFIG, 32'h0, rd);
    chk("config reset", rd, 32'h0000_0380);
    apb(1'b0, ADDR_RATE_SETTING, 32'h0, rd);
    chk("rate reset", rd, 32'h0000_0009);
    apb(1'b0, ADDR_STATUS, 32'h0, rd);
    chk("status reset", rd, 32'h0000_0004);
    apb(1'b0, 12'h0FC, 32'h0, rd);
    chk("unmapped", {31'h0, err}, 32'h1);
    // Master words against the far-end model
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, ADDR_RATE_SETTING, {16'h0000, r.div}, rd);
      apb(1'b1, ADDR_CONFIG, cfg(2'h0, r.wl, {1'b0, r.lsb, 1'b0, r.pol, r.pha, 2'b11}), rd);
      // The new idle level reaches the pin one edge after the write lands
      repeat (2) @(negedge pclk);
      chk("sck idle", {31'h0, sck_out}, {31'h0, r.pol});
      chk("master oe", {29'h0, sck_oe, mosi_oe, miso_oe}, 32'h6);
      {f_pol, f_pha, f_lsb, f_tx} = {r.pol, r.pha, r.lsb, r.far};
      f_bits = {1'b0, r.wl} + 5'd1;
      arm <= 1'b1;
      apb(1'b1, ADDR_DATA, {16'h0000, r.tx}, rd);
      arm <= 1'b0;
      wait_lvl(4'h1);
      chk("rx dma", {31'h0, rd[1]}, 32'h1);
      apb(1'b0, ADDR_DATA, 32'h0, rd);
      chk("rx word", rd, {16'h0000, r.far});
      chk("tx word", {16'h0000, f_rx}, {16'h0000, r.efar});
      chk("bits", {27'h0, f_cnt}, {27'h0, f_bits});
      chk("half period", half, {16'h0000, r.div} + 32'h1);
    end
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, ADDR_CONFIG, cfg(2'(m), 4'h7, 7'h03), rd);
      @(negedge pclk);
      chk("sel oe", {31'h0, sel_oe}, {31'h0, m > 1});
      if (m > 1) chk("sel level", {31'h0, sel_out}, 32'(m % 2));
    end
    apb(1'b1, ADDR_CONFIG, cfg(2'h0, 4'h7, 7'h02), rd);
    @(negedge pclk);
    chk("off oe", {29'h0, sck_oe, mosi_oe, miso_oe}, 32'h0);
    // Slave with active-low select: edges while deselected must be ignored
    apb(1'b1, ADDR_CONFIG, cfg(2'h1, 4'h7, 7'h01), rd);
    apb(1'b1, ADDR_DATA, 32'h0000_00A5, rd);
    slave_word(8'h5A);
    @(negedge pclk);
    chk("unsel oe", {31'h0, miso_oe}, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0, rd);
    chk("unsel rx", {28'h0, rd[6:3]}, 32'h0);
    sel_drv <= 1'b0;
    repeat (4) @(posedge pclk);
    slave_word(8'h3C);
    @(negedge pclk);
    chk("slave oe", {29'h0, sck_oe, mosi_oe, miso_oe}, 32'h1);
    chk("slave out", {24'h0, got}, 32'h0000_00A5);
    apb(1'b0, ADDR_DATA, 32'h0, rd);
    chk("slave in", rd, 32'h0000_003C);
    sel_drv <= 1'b1;
    apb(1'b1, ADDR_CONFIG, cfg(2'h1, 4'h7, 7'h11), rd);
    @(negedge pclk);
    chk("high sel", {31'h0, miso_oe}, 32'h1);
    @(posedge pclk);
    {sel_drv, cts} <= 2'b00;
    repeat (2) @(negedge pclk);
    chk("high unsel", {31'h0, miso_oe}, 32'h0);
    // Flow control holds the master off while the buffer overfills
    apb(1'b1, ADDR_CONFIG, cfg(2'h0, 4'h7, 7'h43), rd);
    for (int k = 0; k < 9; k++) apb(1'b1, ADDR_DATA, 32'(k), rd);
    repeat (20) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0, rd);
    chk("tx full", {20'h0, rd[11:0]}, 32'h0000_0400);
    cts <= 1'b1;
    wait_lvl(4'h8);
    @(negedge pclk);
    chk("dma full", {30'h0, dma_tx_req, dma_rx_req}, 32'h3);
    for (int k = 0; k < 8; k++) apb(1'b0, ADDR_DATA, 32'h0, rd);
    @(negedge pclk);
    chk("dma empty", {30'h0, dma_tx_req, dma_rx_req}, 32'h2);
    // Reset in mid-run must bring the registers back to their reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CONFIG, 32'h0, rd);
    chk("config rst2", rd, 32'h0000_0380);
    apb(1'b0, ADDR_RATE_SETTING, 32'h0, rd);
    chk("rate rst2", rd, 32'h0000_0009);
    apb(1'b0, ADDR_STATUS, 32'h0, rd);
    chk("status rst2", rd, 32'h0000_0004);
    wrap_up();
  end
endmodule

`default_nettype wire

// ==== logic/spi_core_pkg.sv ====
package spi_core_pkg;

  // Data path and buffer shape
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam int SCNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
  localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [SCNT_W-1:0] SCNT_ONE = 5'h01;
  localparam logic [3:0] WL_MAX = 4'hF;

  // Register byte addresses on the APB
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_RATE_SETTING = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_THRESH = 12'h010;

  // Select line modes
  localparam logic [1:0] MODE_3WIRE = 2'h0;
  localparam logic [1:0] MODE_4WIRE_IN = 2'h1;

  // Clock figures: APB rate and fastest master SCK
  localparam longint PCLK_HZ = 200_000_000;
  localparam longint SCK_MAX_HZ = 10_000_000;
  localparam longint SLAVE_SCK_RATIO = 10;
  // SCK = pclk / (2 * (divider + 1)); reset value gives the fastest documented rate
  localparam logic [15:0] DIVIDER_RST = 16'(PCLK_HZ / (2 * SCK_MAX_HZ) - 1);

  // Configuration register layout, bit 0 is enable
  typedef struct packed {
    logic [1:0] select_line_mode;
    logic [3:0] word_length_minus_one;
    logic flow_ctrl_en;
    logic shift_order_select;
    logic select_polarity;
    logic sck_idle_level;
    logic sck_phase_select;
    logic master_en;
    logic enable;
  } config_s;
  localparam config_s CONFIG_RST = '{select_line_mode: 2'h0, word_length_minus_one: 4'h7,
                                     default: 1'b0};

  // Status register layout, bit 0 is the sticky receive overrun flag
  typedef struct packed {
    logic busy;
    logic [CNT_W-1:0] tx_level;
    logic [CNT_W-1:0] rx_level;
    logic dma_tx_req;
    logic dma_rx_req;
    logic rx_overrun;
  } status_s;
  localparam int STAT_OVR_BIT = 0;

  // Buffer thresholds register layout
  typedef struct packed {
    logic [CNT_W-1:0] rx_thresh;
    logic [CNT_W-1:0] tx_thresh;
  } thresh_s;
  localparam thresh_s THRESH_RST = '{rx_thresh: 4'h1, tx_thresh: 4'h1};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } eng_state_e;

  // Whole state of the core
  typedef struct packed {
    config_s cfg;
    logic [15:0] sck_divider;
    thresh_s thr;
    eng_state_e state;
    logic [15:0] div_cnt;
    logic sck_lvl;
    logic [DATA_W-1:0] tx_sr;
    logic [DATA_W-1:0] rx_sr;
    logic [SCNT_W-1:0] smp_cnt;
    logic [SCNT_W-1:0] chg_cnt;
    logic [FIFO_DEPTH-1:0][DATA_W-1:0] tx_mem;
    logic [PTR_W-1:0] tx_wptr;
    logic [PTR_W-1:0] tx_rptr;
    logic [CNT_W-1:0] tx_cnt;
    logic [FIFO_DEPTH-1:0][DATA_W-1:0] rx_mem;
    logic [PTR_W-1:0] rx_wptr;
    logic [PTR_W-1:0] rx_rptr;
    logic [CNT_W-1:0] rx_cnt;
    logic rx_overrun;
    logic [31:0] prdata;
  } core_state_s;

endpackage

// ==== logic/spi_format_clock_core.sv ====
// Summary of operation
// - Master SCK comes from pclk through a 16-bit divider and drives out.
// - Slave mode ignores the divider and takes SCK from the pin.
// - Master SCK reaches 10 MHz at the reset divider value.
// - Words are 1 to 16 bits; length field holds length minus one.
// - Order select 0 shifts MSB first, 1 shifts LSB first, both ways.
// - Select polarity 0 means active low, 1 active high.
// - Phase 0 samples mid-bit on leading edge; phase 1 at bit transition.
// - SCK idles low with idle level 0, high with idle level 1.
// - In slave mode external SCK must match programmed phase and polarity.
// - Shift registers move only on edges of the SCK signal.
// - MOSI driven as master, sampled as slave.
// - MISO sampled as master, driven as slave.
// - MISO released when disabled or an unselected 4-wire slave.
// - SCK is an output as master and an input as slave.
// - Select: output 4-wire single master, input 4-wire others, unused 3-wire.
// - Transmit and receive each have an eight-entry buffer.
// - DMA requests raise when buffer levels cross programmed thresholds.
// - With flow control on, master waits for clear-to-send before words.
// - Mode 0 is 3-wire, 1 is 4-wire input, 2 or 3 single master.
// - In single master mode the mode LSB sets the select pin level.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module spi_format_clock_core
  import spi_core_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic sel_in,
  output logic sel_out,
  output logic sel_oe,
  input wire logic clear_to_send,
  output logic dma_tx_req,
  output logic dma_rx_req
);

  core_state_s s_reg;
  core_state_s s_next;

  logic is_master;
  logic is_slave;
  logic sel_active;
  logic slave_gate;
  logic tx_empty;
  logic tx_full;
  logic rx_full;
  logic tx_bit;
  logic [SCNT_W-1:0] word_bits;
  logic apb_setup;
  logic apb_access;
  logic addr_mapped;
  logic single_master;

  // Mode decode shared by the engine and the pins
  assign is_master = s_reg.cfg.enable & s_reg.cfg.master_en;
  assign is_slave = s_reg.cfg.enable & ~s_reg.cfg.master_en;
  assign sel_active = s_reg.cfg.select_polarity ? sel_in : ~sel_in;
  // 3-wire slave has nothing to gate SCK, so stray edges shift in
  assign slave_gate = (s_reg.cfg.select_line_mode == MODE_3WIRE) | sel_active;
  assign single_master = s_reg.cfg.select_line_mode[1];
  assign tx_empty = (s_reg.tx_cnt == '0);
  assign tx_full = (s_reg.tx_cnt == CNT_FULL);
  assign rx_full = (s_reg.rx_cnt == CNT_FULL);
  assign word_bits = {1'b0, s_reg.cfg.word_length_minus_one} + SCNT_ONE;
  // Serial out bit depends on shift order
  assign tx_bit = s_reg.cfg.shift_order_select ? s_reg.tx_sr[0] : s_reg.tx_sr[DATA_W-1];

  // APB handshake: zero wait states, error on unmapped addresses
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  assign addr_mapped = (paddr == ADDR_CONFIG) | (paddr == ADDR_RATE_SETTING) |
                       (paddr == ADDR_DATA) | (paddr == ADDR_STATUS) | (paddr == ADDR_THRESH);
  assign pready = 1'b1;
  assign pslverr = apb_access & ~addr_mapped;
  assign prdata = s_reg.prdata;

  // Pin directions and levels
  assign sck_out = s_reg.sck_lvl;
  assign sck_oe = is_master;
  assign mosi_out = tx_bit;
  assign mosi_oe = is_master;
  assign miso_out = tx_bit;
  assign miso_oe = is_slave & slave_gate;
  assign sel_out = s_reg.cfg.select_line_mode[0];
  assign sel_oe = is_master & single_master;

  // Service requests compare transmit free space and receive level against thresholds
  assign dma_tx_req = (CNT_FULL - s_reg.tx_cnt) >= s_reg.thr.tx_thresh;
  assign dma_rx_req = s_reg.rx_cnt >= s_reg.thr.rx_thresh;

  // Next-state logic: registers, buffers and the shift engine
  always_comb begin
    logic lead;
    logic trail;
    logic sample;
    logic change;
    logic bit_in;
    logic [DATA_W-1:0] rx_new;
    logic [DATA_W-1:0] word;
    logic push_tx;
    logic pop_tx;
    logic push_rx;
    logic pop_rx;
    logic start;
    status_s st;
    lead = 1'b0;
    trail = 1'b0;
    sample = 1'b0;
    change = 1'b0;
    bit_in = 1'b0;
    rx_new = '0;
    word = '0;
    push_tx = 1'b0;
    pop_tx = 1'b0;
    push_rx = 1'b0;
    pop_rx = 1'b0;
    start = 1'b0;
    st = '{busy: (s_reg.state == ST_SHIFT), tx_level: s_reg.tx_cnt, rx_level: s_reg.rx_cnt,
           dma_tx_req: dma_tx_req, dma_rx_req: dma_rx_req, rx_overrun: s_reg.rx_overrun};
    s_next = s_reg;

    // SCK edges: own divider as master, pin transitions as slave
    if (is_master) begin
      if (s_reg.state == ST_SHIFT) begin
        if (s_reg.div_cnt >= s_reg.sck_divider) begin
          s_next.div_cnt = '0;
          s_next.sck_lvl = ~s_reg.sck_lvl;
          lead = (s_reg.sck_lvl == s_reg.cfg.sck_idle_level);
          trail = ~lead;
        end else begin
          s_next.div_cnt = s_reg.div_cnt + 16'h0001;
        end
      end else begin
        s_next.sck_lvl = s_reg.cfg.sck_idle_level;
      end
    end else begin
      s_next.sck_lvl = sck_in;
      if (s_reg.state == ST_SHIFT && slave_gate) begin
        lead = (s_reg.sck_lvl == s_reg.cfg.sck_idle_level) &&
               (sck_in != s_reg.cfg.sck_idle_level);
        trail = (s_reg.sck_lvl != s_reg.cfg.sck_idle_level) &&
                (sck_in == s_reg.cfg.sck_idle_level);
      end
    end

    // Phase chooses which edge samples and which one moves data
    sample = s_reg.cfg.sck_phase_select ? trail : lead;
    change = s_reg.cfg.sck_phase_select ? lead : trail;
    bit_in = is_master ? miso_in : mosi_in;

    if (sample) begin
      if (s_reg.cfg.shift_order_select) begin
        rx_new = {bit_in, s_reg.rx_sr[DATA_W-1:1]};
        word = rx_new >> (WL_MAX - s_reg.cfg.word_length_minus_one);
      end else begin
        rx_new = {s_reg.rx_sr[DATA_W-2:0], bit_in};
        word = rx_new;
      end
      s_next.rx_sr = rx_new;
      s_next.smp_cnt = s_reg.smp_cnt + SCNT_ONE;
      push_rx = (s_next.smp_cnt == word_bits);
    end

    // Phase 1 presents the first bit at the first edge, so skip that shift
    if (change) begin
      s_next.chg_cnt = s_reg.chg_cnt + SCNT_ONE;
      if (!(s_reg.cfg.sck_phase_select && s_reg.chg_cnt == '0)) begin
        s_next.tx_sr = s_reg.cfg.shift_order_select ? (s_reg.tx_sr >> 1) : (s_reg.tx_sr << 1);
      end
    end

    // Word closes on the first trailing edge at or after the last sample
    if (trail && s_next.smp_cnt == word_bits) begin
      s_next.state = ST_IDLE;
    end
    // Deselected slave drops a partial word; disable stops everything
    if ((is_slave && !slave_gate) || !s_reg.cfg.enable) begin
      s_next.state = ST_IDLE;
    end

    // Start of a word
    if (s_reg.state == ST_IDLE) begin
      if (is_master) begin
        start = !tx_empty && (!s_reg.cfg.flow_ctrl_en || clear_to_send) &&
                !(s_reg.cfg.select_line_mode == MODE_4WIRE_IN && sel_active);
      end else if (is_slave) begin
        start = slave_gate;
      end
    end
    if (start) begin
      pop_tx = !tx_empty;
      // Slave with nothing queued answers with zeros
      word = tx_empty ? '0 : s_reg.tx_mem[s_reg.tx_rptr];
      s_next.tx_sr = s_reg.cfg.shift_order_select ? word :
                     (word << (WL_MAX - s_reg.cfg.word_length_minus_one));
      s_next.rx_sr = '0;
      s_next.smp_cnt = '0;
      s_next.chg_cnt = '0;
      s_next.div_cnt = '0;
      s_next.state = ST_SHIFT;
    end

    // APB read data is captured in the setup cycle
    if (apb_setup && !pwrite) begin
      case (paddr)
        ADDR_CONFIG: s_next.prdata = 32'(s_reg.cfg);
        ADDR_RATE_SETTING: s_next.prdata = 32'(s_reg.sck_divider);
        ADDR_DATA: s_next.prdata = rx_full || s_reg.rx_cnt != '0 ?
                                   32'(s_reg.rx_mem[s_reg.rx_rptr]) : '0;
        ADDR_STATUS: s_next.prdata = 32'(st);
        ADDR_THRESH: s_next.prdata = 32'(s_reg.thr);
        default: s_next.prdata = '0;
      endcase
    end

    // APB writes and the read pop take effect in the access cycle
    if (apb_access) begin
      if (pwrite) begin
        case (paddr)
          ADDR_CONFIG: s_next.cfg = config_s'(pwdata[$bits(config_s)-1:0]);
          ADDR_RATE_SETTING: s_next.sck_divider = pwdata[15:0];
          ADDR_DATA: push_tx = !tx_full;
          ADDR_STATUS: begin
            if (pwdata[STAT_OVR_BIT]) begin
              s_next.rx_overrun = 1'b0;
            end
          end
          ADDR_THRESH: s_next.thr = thresh_s'(pwdata[$bits(thresh_s)-1:0]);
          default: ;
        endcase
      end else if (paddr == ADDR_DATA) begin
        pop_rx = (s_reg.rx_cnt != '0);
      end
    end

    // Transmit buffer
    if (push_tx) begin
      s_next.tx_mem[s_reg.tx_wptr] = pwdata[DATA_W-1:0];
      s_next.tx_wptr = s_reg.tx_wptr + PTR_ONE;
    end
    if (pop_tx) begin
      s_next.tx_rptr = s_reg.tx_rptr + PTR_ONE;
    end
    s_next.tx_cnt = s_reg.tx_cnt + (push_tx ? CNT_ONE : '0) - (pop_tx ? CNT_ONE : '0);

    // Receive buffer; overrun set wins over a clear in the same cycle
    if (push_rx && (!rx_full || pop_rx)) begin
      s_next.rx_mem[s_reg.rx_wptr] = word;
      s_next.rx_wptr = s_reg.rx_wptr + PTR_ONE;
    end else if (push_rx) begin
      s_next.rx_overrun = 1'b1;
      push_rx = 1'b0;
    end
    if (pop_rx) begin
      s_next.rx_rptr = s_reg.rx_rptr + PTR_ONE;
    end
    s_next.rx_cnt = s_reg.rx_cnt + (push_rx ? CNT_ONE : '0) - (pop_rx ? CNT_ONE : '0);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{cfg: CONFIG_RST, sck_divider: DIVIDER_RST, thr: THRESH_RST,
                 state: ST_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [15:0] gap_cnt;
  // Cycles since the last master SCK toggle or word start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt <= '0;
    end else if (s_reg.state != ST_SHIFT || sck_out != s_next.sck_lvl) begin
      gap_cnt <= '0;
    end else begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end

  property p_div_rate;
    is_master && s_reg.state == ST_SHIFT && $stable(s_reg.sck_divider) && $changed(sck_out)
      |-> $past(gap_cnt) == s_reg.sck_divider;
  endproperty
  a_div_rate: assert property (p_div_rate) else $error("SCK half period off divider");

  property p_slave_no_drive;
    !s_reg.cfg.master_en |-> !sck_oe && !mosi_oe;
  endproperty
  a_slave_no_drive: assert property (p_slave_no_drive) else $error("Slave drives SCK");

  property p_idle_level;
    is_master && s_reg.state == ST_IDLE |=> sck_out == $past(s_reg.cfg.sck_idle_level);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("SCK not at idle level");

  property p_miso_release;
    !s_reg.cfg.enable || (is_slave && s_reg.cfg.select_line_mode != MODE_3WIRE && !sel_active)
      |-> !miso_oe;
  endproperty
  a_miso_release: assert property (p_miso_release) else $error("MISO driven");

  property p_sel_dir;
    (s_reg.cfg.select_line_mode == MODE_3WIRE || is_slave) |-> !sel_oe;
  endproperty
  a_sel_dir: assert property (p_sel_dir) else $error("Select driven wrongly");

  property p_sel_level;
    is_master && single_master |-> sel_oe && sel_out == s_reg.cfg.select_line_mode[0];
  endproperty
  a_sel_level: assert property (p_sel_level) else $error("Select level wrong");

  // A read pop in the push cycle keeps the level flat, so it is left out
  logic pop_rx_seen;
  assign pop_rx_seen = apb_access & ~pwrite & (paddr == ADDR_DATA);
  property p_word_len;
    s_reg.state == ST_SHIFT && $past(s_reg.smp_cnt) != word_bits && s_reg.smp_cnt == word_bits
      && $stable(s_reg.cfg) && !$past(pop_rx_seen) |-> s_reg.rx_cnt != '0 || s_reg.rx_overrun;
  endproperty
  a_word_len: assert property (p_word_len) else $error("Word not stored");

  property p_unsel_hold;
    is_slave && !slave_gate |=> $stable(s_reg.rx_sr) && s_reg.state == ST_IDLE;
  endproperty
  a_unsel_hold: assert property (p_unsel_hold) else $error("Unselected slave shifted");

  // Within a word the receive register moves only together with an SCK level change
  property p_shift_on_sck;
    $past(s_reg.state) == ST_SHIFT && $changed(s_reg.rx_sr) |-> $changed(s_reg.sck_lvl);
  endproperty
  a_shift_on_sck: assert property (p_shift_on_sck) else $error("Shift without SCK edge");

  property p_flow_hold;
    is_master && s_reg.cfg.flow_ctrl_en && !clear_to_send && s_reg.state == ST_IDLE
      |=> s_reg.state == ST_IDLE;
  endproperty
  a_flow_hold: assert property (p_flow_hold) else $error("Started without CTS");

  property p_rx_dma;
    s_reg.rx_cnt >= s_reg.thr.rx_thresh |-> dma_rx_req;
  endproperty
  a_rx_dma: assert property (p_rx_dma) else $error("RX request missing");

  c_master_word: cover property (is_master && s_reg.state == ST_SHIFT ##1 s_reg.state == ST_IDLE);
  c_slave_word: cover property (is_slave && $rose(s_reg.rx_cnt != '0));
  c_lsb_first: cover property (s_reg.cfg.shift_order_select && s_reg.state == ST_SHIFT);
  c_tx_full: cover property (tx_full);

endmodule

`default_nettype wire
